// File: core/sbaq_arbiter.sv
// shared bus arbiter with next-owner queue and memory mode sequencing
// Functional notes
// [RQ1] among devices, the slot nearest the arbiter wins
// [RQ2] devices beat interrupt sources, which beat processors
// [RQ3] next owner is chosen during the current transfer, no idle gap
// [RQ4] transfers end on source and target handshakes, not a timer
// [RQ5] interlocked: no access until the other block finishes restore
// [RQ6] overlapped: another block may start once the bus is released
// [RQ7] interleaved: two blocks alternate over sequential word addresses
// [RQ8] mode from straps: interlock, else odd/even interleave, else overlap
// [RQ9] interlocked: at most one memory start per 850 ns
// [RQ10] address and data held in registers for the whole access
// [RQ11] requesters ask one access per request; processors ask separately
// [RQ12] queue decision at transfer start, highest requester at that moment
// [RQ13] interleaved: block 1 takes odd words, block 0 even words
// [RQ14] each waiting processor is served once before any repeats
// [RQ15] owner keeps grant until release; queued winner follows next cycle
// [RQ16] after reset no grant, empty queue, mode from straps; reset loads interlock mode, then idle reloads it from the synchronised straps
`timescale 1ns/1ps
`include "sbaq_params.svh"

module sbaq_arbiter import sbaq_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus requests, asynchronous
  input wire logic [`SBAQ_NDEV-1:0] dev_req,
  input wire logic [`SBAQ_NIRQ-1:0] irq_req,
  input wire logic [`SBAQ_NCPU-1:0] cpu_req,
  // grants, one hot over dev, irq, cpu
  output logic [`SBAQ_NREQ-1:0] grant,
  output logic queue_vld,
  // source handshake and transfer content from the owner
  input wire logic src_valid,
  input wire logic [`SBAQ_ADDR_W-1:0] src_addr,
  input wire logic [`SBAQ_DATA_W-1:0] src_wdata,
  input wire logic src_write,
  // memory blocks
  output logic [1:0] mem_start,
  output logic [`SBAQ_ADDR_W-1:0] mem_addr,
  output logic [`SBAQ_DATA_W-1:0] mem_wdata,
  output logic mem_write,
  input wire logic [1:0] mem_ack,
  input wire logic [1:0] mem_busy,
  // static configuration straps
  input wire logic cfg_interlock,
  input wire logic cfg_odd_even,
  output logic [1:0] mem_mode
);
  sbaq_arb_st_t st_q;
  sbaq_arb_st_t st_d;

  logic [`SBAQ_NREQ-1:0] req_s;
  logic [6:0] ctl_s;
  logic [`SBAQ_ADDR_W+`SBAQ_DATA_W:0] dat_s;
  logic src_valid_s;
  logic [1:0] ack_s;
  logic [1:0] busy_s;
  logic interlock_s;
  logic odd_even_s;
  logic src_write_s;
  logic [`SBAQ_ADDR_W-1:0] src_addr_s;
  logic [`SBAQ_DATA_W-1:0] src_wdata_s;
  logic [`SBAQ_NREQ-1:0] req_m;
  logic win_vld;
  logic [`SBAQ_IDX_W-1:0] win_idx;
  logic tgt_blk;
  logic blk_ok;

  sbaq_pick_if pif ();

  sbaq_sync #(.W(`SBAQ_NREQ)) u_req_sync (
    .clk(clk),
    .rst(rst),
    .d({cpu_req, irq_req, dev_req}),
    .q(req_s)
  );

  sbaq_sync #(.W(7)) u_ctl_sync (
    .clk(clk),
    .rst(rst),
    .d({src_valid, mem_ack, mem_busy, cfg_interlock, cfg_odd_even}),
    .q(ctl_s)
  );

  sbaq_sync #(.W(`SBAQ_ADDR_W + `SBAQ_DATA_W + 1)) u_dat_sync (
    .clk(clk),
    .rst(rst),
    .d({src_write, src_addr, src_wdata}),
    .q(dat_s)
  );

  sbaq_rr_pick u_rr (
    .clk(clk),
    .rst(rst),
    .pif(pif)
  );

  assign {src_valid_s, ack_s, busy_s, interlock_s, odd_even_s} = ctl_s;
  assign {src_write_s, src_addr_s, src_wdata_s} = dat_s;

  function automatic logic [`SBAQ_NREQ-1:0] idx_onehot(input logic [`SBAQ_IDX_W-1:0] i);
    logic [`SBAQ_NREQ-1:0] v;
    v = '0;
    v[i] = 1'b1;
    return v;
  endfunction

  // the current owner cannot queue behind itself
  assign req_m = (st_q.state == SBAQ_IDLE) ? req_s : (req_s & ~idx_onehot(st_q.owner));
  assign pif.req = req_m[`SBAQ_CPU_BASE +: `SBAQ_NCPU];

  // fixed priority: devices by slot, then interrupts, then fair processor pick
  always_comb begin
    win_vld = pif.pick_vld; // [RQ2]
    win_idx = `SBAQ_IDX_W'(`SBAQ_CPU_BASE) + `SBAQ_IDX_W'(pif.pick);
    for (int i = `SBAQ_CPU_BASE - 1; i >= 0; i--) begin
      if (req_m[i]) begin // [RQ1] [RQ2]
        win_vld = 1'b1;
        win_idx = `SBAQ_IDX_W'(i);
      end
    end
  end

  // block select and admission per memory mode
  always_comb begin
    if (st_q.mode == SBAQ_MODE_INTERLEAVE) begin
      tgt_blk = src_addr_s[0]; // [RQ7] [RQ13]
    end else begin
      tgt_blk = src_addr_s[`SBAQ_ADDR_W-1];
    end
    if (st_q.mode == SBAQ_MODE_INTERLOCK) begin
      blk_ok = (st_q.blk_wait == 2'h0) && (busy_s == 2'h0) && (st_q.gap == '0); // [RQ5] [RQ9]
    end else begin
      blk_ok = !st_q.blk_wait[tgt_blk] && !busy_s[tgt_blk]; // [RQ6] [RQ7]
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.start = 2'h0;
    pif.take = 1'b0;
    pif.taken = pif.pick;
    if (st_q.gap != '0) begin
      st_d.gap = st_q.gap - `SBAQ_GAP_W'(1);
    end
    st_d.blk_wait = st_q.blk_wait & ~ack_s;
    case (st_q.state)
      SBAQ_IDLE: begin
        if (interlock_s) begin // [RQ8] [RQ16]
          st_d.mode = SBAQ_MODE_INTERLOCK;
        end else if (odd_even_s) begin
          st_d.mode = SBAQ_MODE_INTERLEAVE;
        end else begin
          st_d.mode = SBAQ_MODE_OVERLAP;
        end
        if (win_vld) begin
          st_d.owner = win_idx;
          st_d.grant = idx_onehot(win_idx);
          st_d.fresh = 1'b1;
          st_d.state = SBAQ_WAIT_SRC;
          pif.take = (win_idx >= `SBAQ_IDX_W'(`SBAQ_CPU_BASE)); // [RQ14]
        end
      end
      SBAQ_WAIT_SRC: begin
        if (st_q.fresh) begin
          st_d.fresh = 1'b0;
          st_d.q_vld = win_vld; // [RQ3] [RQ12]
          st_d.q_idx = win_idx;
          pif.take = win_vld && (win_idx >= `SBAQ_IDX_W'(`SBAQ_CPU_BASE)); // [RQ14]
        end
        if (src_valid_s && blk_ok) begin // [RQ4]
          st_d.blk = tgt_blk;
          st_d.start[tgt_blk] = 1'b1;
          st_d.blk_wait[tgt_blk] = 1'b1;
          st_d.addr = src_addr_s; // [RQ10]
          st_d.wdata = src_wdata_s;
          st_d.write = src_write_s;
          st_d.gap = `SBAQ_GAP_W'(`SBAQ_MEM_CYCLE_CYC - 1); // [RQ9]
          st_d.state = SBAQ_XFER;
        end
      end
      SBAQ_XFER: begin
        if (ack_s[st_q.blk]) begin // [RQ4]
          st_d.state = SBAQ_RELEASE;
        end
      end
      SBAQ_RELEASE: begin
        if (!src_valid_s && !req_s[st_q.owner]) begin // [RQ15]
          if (st_q.q_vld) begin
            st_d.owner = st_q.q_idx;
            st_d.grant = idx_onehot(st_q.q_idx); // [RQ3] [RQ15]
            st_d.q_vld = 1'b0;
            st_d.fresh = 1'b1;
            st_d.state = SBAQ_WAIT_SRC;
          end else begin
            st_d.grant = '0;
            st_d.state = SBAQ_IDLE;
          end
        end
      end
      default: begin
        st_d.state = SBAQ_IDLE;
        st_d.grant = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0; // [RQ16]
    end else begin
      st_q <= st_d;
    end
  end

  assign grant = st_q.grant;
  assign queue_vld = st_q.q_vld;
  assign mem_start = st_q.start;
  assign mem_addr = st_q.addr;
  assign mem_wdata = st_q.wdata;
  assign mem_write = st_q.write;
  assign mem_mode = st_q.mode;

  // helper: cycles since the last memory start, saturating
  logic [7:0] since_q;
  logic seen_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      since_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (st_q.start != 2'h0) begin
      since_q <= 8'h01;
      seen_q <= 1'b1;
    end else if (since_q != 8'hFF) begin
      since_q <= since_q + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_grant_one_hot: assert property ($onehot0(st_q.grant))
    else $error("more than one grant"); // [RQ15]
  a_slot_zero_wins: assert property ((st_q.state == SBAQ_IDLE) && req_s[0] |=> st_q.grant[0])
    else $error("nearest device not granted"); // [RQ1]
  a_device_over_rest: assert property ((st_q.state == SBAQ_IDLE) && (req_s[3:0] != 4'h0) |=> st_q.grant[3:0] != 4'h0)
    else $error("device lost to a lower class"); // [RQ2]
  a_irq_over_cpu: assert property ((st_q.state == SBAQ_IDLE) && (req_s[3:0] == 4'h0) && (req_s[7:4] != 4'h0)
    |=> st_q.grant[7:4] != 4'h0) else $error("processor beat an interrupt"); // [RQ2]
  a_queue_at_start: assert property ((st_q.state == SBAQ_WAIT_SRC) && st_q.fresh && win_vld
    |=> st_q.q_vld && st_q.q_idx == $past(win_idx)) else $error("queue not filled at start"); // [RQ12]
  a_handoff_next: assert property ((st_q.state == SBAQ_RELEASE) && !src_valid_s && !req_s[st_q.owner] && st_q.q_vld
    |=> st_q.grant == idx_onehot($past(st_q.q_idx))) else $error("queued winner not granted next"); // [RQ15]
  a_wait_handshake: assert property ((st_q.state == SBAQ_XFER) && !ack_s[st_q.blk] |=> st_q.state == SBAQ_XFER)
    else $error("transfer ended without acknowledge"); // [RQ4]
  a_interlock_serial: assert property ((st_q.start != 2'h0) && (st_q.mode == SBAQ_MODE_INTERLOCK)
    |-> $past(busy_s) == 2'h0) else $error("interlocked start while a block restores"); // [RQ5]
  a_interlock_gap: assert property ((st_q.start != 2'h0) && (st_q.mode == SBAQ_MODE_INTERLOCK) && $past(seen_q)
    |-> $past(since_q) >= 8'(`SBAQ_MEM_CYCLE_CYC - 1)) else $error("interlocked starts too close"); // [RQ9]
  a_overlap_free: assert property ((st_q.start != 2'h0) && (st_q.mode != SBAQ_MODE_INTERLOCK)
    |-> ($past(busy_s) & st_q.start) == 2'h0) else $error("start on a busy block"); // [RQ6]
  a_odd_even_sel: assert property ((st_q.start != 2'h0) && (st_q.mode == SBAQ_MODE_INTERLEAVE)
    |-> st_q.start[1] == st_q.addr[0]) else $error("interleave block mismatch"); // [RQ13]
  a_addr_held: assert property ((st_q.state == SBAQ_XFER) |=> $stable(st_q.addr) && $stable(st_q.wdata))
    else $error("address changed during access"); // [RQ10]
  a_reset_clear: assert property ($past(rst) |-> (st_q.grant == '0) && !st_q.q_vld)
    else $error("grant or queue left after reset"); // [RQ16]
  a_release_handoff: assert property ((st_q.state == SBAQ_RELEASE) && !src_valid_s && !req_s[st_q.owner] && st_q.q_vld
    |=> (st_q.state == SBAQ_WAIT_SRC) && st_q.fresh) else $error("idle gap before queued owner"); // [RQ3]
  a_idle_no_grant: assert property ((st_q.state == SBAQ_IDLE) |-> (st_q.grant == '0) && (st_q.start == 2'h0))
    else $error("grant or start while idle"); // [RQ15]
  a_owner_grant: assert property ((st_q.state != SBAQ_IDLE) |-> st_q.grant == idx_onehot(st_q.owner))
    else $error("grant does not match owner"); // [RQ15]
  a_grant_kept: assert property ((st_q.state == SBAQ_XFER) |=> $stable(st_q.grant))
    else $error("grant moved during transfer"); // [RQ15]
  a_release_hold: assert property ((st_q.state == SBAQ_RELEASE) && src_valid_s |=> $stable(st_q.grant))
    else $error("grant moved before release"); // [RQ15]
  a_start_one_block: assert property ($onehot0(st_q.start))
    else $error("two blocks started at once"); // [RQ6]
  a_start_in_xfer: assert property ((st_q.start != 2'h0) |-> (st_q.state == SBAQ_XFER))
    else $error("start outside a transfer"); // [RQ4]
  a_mode_interlock: assert property ((st_q.state == SBAQ_IDLE) && interlock_s |=> st_q.mode == SBAQ_MODE_INTERLOCK)
    else $error("interlock strap ignored"); // [RQ8]
  a_mode_overlap: assert property ((st_q.state == SBAQ_IDLE) && !interlock_s && !odd_even_s
    |=> st_q.mode == SBAQ_MODE_OVERLAP) else $error("overlap mode not taken"); // [RQ8]
  a_mode_interleave: assert property ((st_q.state == SBAQ_IDLE) && !interlock_s && odd_even_s
    |=> st_q.mode == SBAQ_MODE_INTERLEAVE) else $error("interleave mode not taken"); // [RQ8]
  a_queue_held: assert property (st_q.q_vld && (st_q.state != SBAQ_RELEASE) |=> st_q.q_vld && $stable(st_q.q_idx))
    else $error("queued winner replaced"); // [RQ12]
  a_slot_one_next: assert property ((st_q.state == SBAQ_IDLE) && !req_s[0] && req_s[1] |=> st_q.grant[1])
    else $error("second slot not granted"); // [RQ1]
  a_cpu_last: assert property ((st_q.state == SBAQ_IDLE) && (req_s[7:0] == 8'h00) && (req_s[11:8] != 4'h0)
    |=> st_q.grant[11:8] != 4'h0) else $error("lone processor not granted"); // [RQ2]
  a_wait_mark: assert property ((st_q.start != 2'h0) |-> (st_q.blk_wait & st_q.start) == st_q.start)
    else $error("started block not marked"); // [RQ5]
  a_interlock_hold: assert property ((st_q.state == SBAQ_WAIT_SRC) && (st_q.mode == SBAQ_MODE_INTERLOCK)
    && (busy_s != 2'h0) |=> st_q.start == 2'h0) else $error("interlocked start while busy"); // [RQ5]


  c_interlock_start: cover property ((st_q.start != 2'h0) && (st_q.mode == SBAQ_MODE_INTERLOCK));
  c_overlap_start: cover property ((st_q.start != 2'h0) && (st_q.mode == SBAQ_MODE_OVERLAP));
  c_interleave_odd: cover property (st_q.start[1] && (st_q.mode == SBAQ_MODE_INTERLEAVE));
  c_queued_handoff: cover property ((st_q.state == SBAQ_RELEASE) && st_q.q_vld ##1 (st_q.state == SBAQ_WAIT_SRC));
  c_cpu_take: cover property (pif.take && (pif.taken != 2'h0));
endmodule

// File: core/sbaq_params.svh
// constants for the shared bus arbiter and access queue
`ifndef SBAQ_PARAMS_SVH
`define SBAQ_PARAMS_SVH

// requester counts, slot 0 nearest the arbiter
`define SBAQ_NDEV 4
`define SBAQ_NIRQ 4
`define SBAQ_NCPU 4
`define SBAQ_NREQ 12
`define SBAQ_IDX_W 4
`define SBAQ_CPU_W 2
// base indices of the request classes in the flat request vector
`define SBAQ_IRQ_BASE 4
`define SBAQ_CPU_BASE 8

// transfer content widths
`define SBAQ_ADDR_W 15
`define SBAQ_DATA_W 16

// timing
`define SBAQ_CLK_NS 50
`define SBAQ_MEM_CYCLE_NS 850
`define SBAQ_MEM_CYCLE_CYC ((`SBAQ_MEM_CYCLE_NS + `SBAQ_CLK_NS - 1) / `SBAQ_CLK_NS)
`define SBAQ_GAP_W 5

`endif

// File: core/sbaq_pick_if.sv
// processor fairness picker hookup
`timescale 1ns/1ps
`include "sbaq_params.svh"

interface sbaq_pick_if;
  logic [`SBAQ_NCPU-1:0] req;
  logic take;
  logic [`SBAQ_CPU_W-1:0] taken;
  logic [`SBAQ_CPU_W-1:0] pick;
  logic pick_vld;
  modport arb (output req, output take, output taken, input pick, input pick_vld);
  modport rr (input req, input take, input taken, output pick, output pick_vld);
endinterface

// File: core/sbaq_pkg.sv
// types for the shared bus arbiter and access queue
`include "sbaq_params.svh"

package sbaq_pkg;

  typedef enum logic [1:0] {
    SBAQ_IDLE,
    SBAQ_WAIT_SRC,
    SBAQ_XFER,
    SBAQ_RELEASE
  } sbaq_state_t;

  typedef enum logic [1:0] {
    SBAQ_MODE_INTERLOCK,
    SBAQ_MODE_OVERLAP,
    SBAQ_MODE_INTERLEAVE
  } sbaq_mode_t;

  typedef struct packed {
    sbaq_state_t state;
    logic [`SBAQ_IDX_W-1:0] owner;
    logic q_vld;
    logic [`SBAQ_IDX_W-1:0] q_idx;
    logic fresh;
    logic blk;
    logic [1:0] blk_wait;
    logic [`SBAQ_GAP_W-1:0] gap;
    sbaq_mode_t mode;
    logic [`SBAQ_NREQ-1:0] grant;
    logic [1:0] start;
    logic [`SBAQ_ADDR_W-1:0] addr;
    logic [`SBAQ_DATA_W-1:0] wdata;
    logic write;
  } sbaq_arb_st_t;

endpackage

// File: core/sbaq_rr_pick.sv
// round robin pick among processors
`timescale 1ns/1ps
`include "sbaq_params.svh"

module sbaq_rr_pick import sbaq_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // picker port
  sbaq_pick_if.rr pif
);
  typedef struct packed {
    logic [`SBAQ_CPU_W-1:0] last;
  } sbaq_rr_st_t;

  sbaq_rr_st_t st_q;
  sbaq_rr_st_t st_d;

  // search starts just after the last taken processor
  always_comb begin
    logic [`SBAQ_CPU_W-1:0] idx;
    idx = '0;
    pif.pick = '0;
    pif.pick_vld = 1'b0;
    for (int i = `SBAQ_NCPU; i >= 1; i--) begin
      idx = st_q.last + `SBAQ_CPU_W'(i);
      if (pif.req[idx]) begin // [RQ14]
        pif.pick = idx;
        pif.pick_vld = 1'b1;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    if (pif.take) begin
      st_d.last = pif.taken;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_rr_no_repeat: assert property (pif.take ##1 (pif.pick_vld && (pif.req & ~(`SBAQ_NCPU'(1) << st_q.last)) != '0)
    |-> pif.pick != st_q.last) else $error("processor picked twice in a row"); // [RQ14]
endmodule

// File: core/sbaq_sync.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps

module sbaq_sync import sbaq_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sbaq_sync_st_t;

  sbaq_sync_st_t st_q;
  sbaq_sync_st_t st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// File: sim/sbaq_mem_model.sv
// two memory block partner model answering the arbiter's start pulses
`timescale 1ns/1ps

module sbaq_mem_model #(
  parameter int RESTORE = 30
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus side
  input wire logic [1:0] mem_start,
  input wire logic src_valid,
  input wire logic slow,
  // handshake back to the arbiter
  output logic [1:0] mem_ack,
  output logic [1:0] mem_busy
);
  logic [5:0] cnt_q [2];
  logic [1:0] rest_q;

  always_ff @(posedge clk) begin
    for (int b = 0; b < 2; b++) begin
      if (rst) begin
        mem_ack[b] <= 1'b0;
        mem_busy[b] <= 1'b0;
        rest_q[b] <= 1'b0;
        cnt_q[b] <= '0;
      end else if (mem_start[b]) begin
        mem_busy[b] <= 1'b1;
        rest_q[b] <= 1'b0;
        cnt_q[b] <= slow ? 6'h08 : 6'h01;
      end else if (mem_busy[b] && !mem_ack[b] && !rest_q[b]) begin
        if (cnt_q[b] <= 6'h01) begin
          mem_ack[b] <= 1'b1;
        end else begin
          cnt_q[b] <= cnt_q[b] - 6'h01;
        end
      end else if (mem_ack[b] && !src_valid) begin
        mem_ack[b] <= 1'b0;
        rest_q[b] <= 1'b1;
        cnt_q[b] <= 6'(RESTORE);
      end else if (rest_q[b]) begin
        if (cnt_q[b] <= 6'h01) begin
          mem_busy[b] <= 1'b0;
          rest_q[b] <= 1'b0;
        end else begin
          cnt_q[b] <= cnt_q[b] - 6'h01;
        end
      end
    end
  end
endmodule

// File: sim/test_sbaq_arbiter.sv
// self-checking bench for the shared bus arbiter
`timescale 1ns/1ps
`include "sbaq_params.svh"

module test_sbaq_arbiter import sbaq_pkg::*; ();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reqs = '0;
  logic src_valid = 1'b0;
  logic src_write = 1'b0;
  logic slow = 1'b0;
  logic [14:0] src_addr = '0;
  logic [15:0] src_wdata = '0;
  logic cfg_interlock = 1'b1;
  logic cfg_odd_even = 1'b0;
  logic [11:0] grant;
  logic [11:0] g_prev = '0;
  logic q_prev = 1'b0;
  logic queue_vld;
  logic mem_write;
  logic [1:0] mem_start;
  logic [1:0] mem_ack;
  logic [1:0] mem_busy;
  logic [1:0] mem_mode;
  logic [14:0] mem_addr;
  logic [15:0] mem_wdata;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int last_start = -100;
  int overlaps = 0;
  int exp_g [$];
  logic [33:0] exp_m [$];

  always #25 clk = ~clk;

  sbaq_arbiter u_dut (.clk(clk), .rst(rst), .dev_req(reqs[3:0]), .irq_req(reqs[7:4]), .cpu_req(reqs[11:8]),
    .grant(grant), .queue_vld(queue_vld), .src_valid(src_valid), .src_addr(src_addr), .src_wdata(src_wdata),
    .src_write(src_write), .mem_start(mem_start), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_write(mem_write), .mem_ack(mem_ack), .mem_busy(mem_busy), .cfg_interlock(cfg_interlock),
    .cfg_odd_even(cfg_odd_even), .mem_mode(mem_mode));

  sbaq_mem_model u_mem (.clk(clk), .rst(rst), .mem_start(mem_start), .src_valid(src_valid), .slow(slow),
    .mem_ack(mem_ack), .mem_busy(mem_busy));

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(inout int k);
    @(negedge clk);
    k++;
    if (k > 400) begin
      fail_count++;
      give_verdict();
    end
  endtask

  // one transfer by whichever requester holds the grant
  task automatic serve(input int n, input int md, input logic [14:0] base);
    int idx;
    int k;
    logic [14:0] a;
    logic blk;
    k = 0;
    while (grant == 0) tick(k);
    @(negedge clk);
    idx = $clog2(grant);
    a = 15'($urandom);
    if (md == 1) a[14] = n[0];
    if (md == 2) a = base + 15'(n);
    blk = (md == 2) ? a[0] : a[14];
    src_addr = a;
    src_wdata = 16'($urandom);
    src_write = n[0];
    slow = n[1];
    @(negedge clk);
    src_valid = 1'b1;
    exp_m.push_back({2'b01 << blk, src_write, src_addr, src_wdata});
    k = 0;
    while (mem_ack == 0) tick(k);
    @(negedge clk);
    src_valid = 1'b0;
    reqs[idx] = 1'b0;
    k = 0;
    while (grant[idx]) tick(k);
    @(negedge clk);
  endtask

  // watches grants and memory starts against the noted expectations
  always @(negedge clk) begin
    cyc++;
    if (!rst) begin
      if (grant !== g_prev && grant != 0) begin
        chk(34'($countones(grant)), 34'd1);
        chk(34'(grant), 34'(12'h001 << exp_g.pop_front()));
      end
      if (g_prev != 0 && grant == 0 && q_prev) chk(34'd1, 34'd0);
      if (mem_start != 0) begin
        chk({mem_start, mem_write, mem_addr, mem_wdata}, exp_m.pop_front());
        if (mem_mode == SBAQ_MODE_INTERLOCK) begin
          chk(34'(cyc - last_start >= 17), 34'd1);
          chk(34'(mem_busy), 34'd0);
        end
        if (mem_busy != 0) overlaps++;
        last_start = cyc;
      end
      g_prev = grant;
      q_prev = queue_vld;
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    int order [6] = '{1, 3, 4, 9, 8, 9};
    logic [14:0] base;
    void'($urandom(94));
    for (int md = 0; md < 3; md++) begin
      cfg_interlock = (md == 0);
      cfg_odd_even = (md == 2);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(34'(grant), 34'd0);
      chk(34'(queue_vld), 34'd0);
      repeat (6) @(negedge clk);
      chk(34'(mem_mode), 34'(md));
      base = 15'($urandom) & 15'h7FF0;
      foreach (order[i]) exp_g.push_back(order[i]);
      reqs = 12'h31A;
      for (int n = 0; n < 6; n++) begin
        serve(n, md, base);
        if (n == 3) reqs[9] = 1'b1;
      end
      chk(34'(exp_g.size()), 34'd0);
      if (md > 0) chk(34'(overlaps > 0), 34'd1);
      overlaps = 0;
    end
    give_verdict();
  end
endmodule
